// >>> seecp_fifo.sv
// Small valid/ready FIFO for read words
`timescale 1ns/1ps
module seecp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	wire logic full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire logic empty = (wp_r == rp_r);
	wire logic push = in_valid && !full;
	wire logic pop = out_valid && out_ready;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wp_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (flush) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule : seecp_fifo

// >>> seecp_master.sv
// Link master model for the serial EEPROM command port
`timescale 1ns/1ps
module seecp_master (
	output logic select_in,
	output logic serial_clock_in,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe_n
);
	// ------
	// Master
	// ------
	logic [16:0] q;
	// Released line shows a wrong value, never a lucky one
	wire line = serial_data_oe_n ? ~serial_data_out : serial_data_out;
	initial begin
		select_in = 0;
		serial_clock_in = 0;
		serial_data_in = 0;
	end
	// Clock stands still between frames; sample on the fall
	task automatic clk_bit(input logic b);
		serial_data_in = b;
		#62 serial_clock_in = 1;
		#63 serial_clock_in = 0;
		q = {q[15:0], line};
	endtask : clk_bit
	task automatic cycle(input logic [26:0] v, input int n, input bit rd);
		select_in = 1;
		#200;
		for (int i = n - 1; i >= 0; i--) clk_bit(v[i]);
		if (rd) repeat (16) clk_bit(1'b0);
		#100 select_in = 0;
		#1000;
	endtask : cycle
	task automatic poll(output logic ready);
		select_in = 1;
		#200 ready = line;
		select_in = 0;
		#1000;
	endtask : poll
endmodule : seecp_master

// >>> seecp_pkg.sv
// Constants shared by the serial EEPROM command port
package seecp_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int WORDS = 64;
	localparam int FIFO_DEPTH = 32;
	// Opcodes
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	// Extended sub-codes in the upper address bits
	localparam logic [1:0] EXT_DIS = 2'h0;
	localparam logic [1:0] EXT_FILL = 2'h1;
	localparam logic [1:0] EXT_CLEAR = 2'h2;
	localparam logic [1:0] EXT_EN = 2'h3;
	// Field lengths in link clocks
	localparam logic [4:0] OPC_BITS = 5'h02;
	localparam logic [4:0] ADR_BITS = 5'h06;
	localparam logic [4:0] DAT_BITS = 5'h10;
	localparam logic [DATA_W-1:0] ERASED = 16'hFFFF;
	// Programming time
	localparam int PROG_MS = 15;
	localparam int CLK_MHZ = 100;
	localparam int PROG_CYCLES = PROG_MS * 1000 * CLK_MHZ;
	typedef enum logic [2:0] {
		SEECP_IDLE, SEECP_OPC, SEECP_ADR, SEECP_DAT, SEECP_RD, SEECP_DONE
	} seecp_state_t;
endpackage : seecp_pkg

// >>> seecp_port.sv
// Serial EEPROM command port: link decoder, array and programming timer
`timescale 1ns/1ps

module seecp_port #(
	parameter int PROG_CYCLES = seecp_pkg::PROG_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic select_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe_n,
	output logic busy,
	output logic write_enabled,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [15:0] rd_data
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [2:0] cs_s_r;
	logic [2:0] sk_s_r;
	logic [1:0] di_s_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_s_r <= 3'h0;
			sk_s_r <= 3'h0;
			di_s_r <= 2'h0;
		end else begin
			cs_s_r <= {cs_s_r[1:0], select_in};
			sk_s_r <= {sk_s_r[1:0], serial_clock_in};
			di_s_r <= {di_s_r[0], serial_data_in};
		end
	end
	wire logic cs = cs_s_r[1];
	wire logic cs_rise = cs_s_r[1] && !cs_s_r[2];
	wire logic cs_fall = !cs_s_r[1] && cs_s_r[2];
	// Only clock rises seen while selected count
	wire logic sk_rise = cs && sk_s_r[1] && !sk_s_r[2];
	wire logic di = di_s_r[1];

	// ------------------------------------------------------------
	// Command decoder
	// ------------------------------------------------------------
	seecp_pkg::seecp_state_t st_r;
	seecp_pkg::seecp_state_t st_nxt;
	logic [4:0] cnt_r;
	logic [1:0] opc_r;
	logic [5:0] adr_r;
	logic [15:0] dat_r;
	logic [16:0] sh_r;
	logic we_r;
	logic ready_show_r;
	logic [31:0] tmr_r;
	logic prog_r;
	logic [5:0] prog_adr_r;
	logic [15:0] prog_word_r;
	logic prog_all_r;
	logic do_r;
	logic oe_n_r;
	logic [15:0] mem [seecp_pkg::WORDS];

	// Fill is the only extended command that carries data
	function automatic logic fill_decode(input logic [1:0] opc,
		input logic [1:0] top);
		return opc == seecp_pkg::OP_EXT && top == seecp_pkg::EXT_FILL;
	endfunction : fill_decode

	wire logic [4:0] cnt_inc = cnt_r + 5'h01;
	wire logic is_ext = (opc_r == seecp_pkg::OP_EXT);
	wire logic [1:0] ext = adr_r[5:4];
	wire logic [5:0] adr_next = {adr_r[4:0], di};
	wire logic [15:0] dat_next = {dat_r[14:0], di};
	wire logic cmd_fill = fill_decode(opc_r, ext);
	// Decided on the final address bit; adr_r still lacks it there
	wire logic needs_data = (opc_r == seecp_pkg::OP_WRITE) ||
		fill_decode(opc_r, adr_next[5:4]);
	wire logic last_opc = sk_rise && st_r == seecp_pkg::SEECP_OPC &&
		cnt_inc == seecp_pkg::OPC_BITS;
	wire logic last_adr = sk_rise && st_r == seecp_pkg::SEECP_ADR &&
		cnt_inc == seecp_pkg::ADR_BITS;
	wire logic last_dat = sk_rise && st_r == seecp_pkg::SEECP_DAT &&
		cnt_inc == seecp_pkg::DAT_BITS;
	wire logic start_bit = sk_rise && st_r == seecp_pkg::SEECP_IDLE && di;
	// Read decision made on the final address bit
	wire logic rd_go = last_adr && opc_r == seecp_pkg::OP_READ &&
		!prog_r;

	always_comb begin
		st_nxt = st_r;
		if (!cs || cs_rise) begin
			st_nxt = seecp_pkg::SEECP_IDLE;
		end else if (sk_rise) begin
			unique case (st_r)
			seecp_pkg::SEECP_IDLE:
				if (di)
					st_nxt = seecp_pkg::SEECP_OPC;
			seecp_pkg::SEECP_OPC:
				if (last_opc)
					st_nxt = seecp_pkg::SEECP_ADR;
			seecp_pkg::SEECP_ADR:
				if (last_adr) begin
					if (opc_r == seecp_pkg::OP_READ)
						st_nxt = seecp_pkg::SEECP_RD;
					else if (needs_data)
						st_nxt = seecp_pkg::SEECP_DAT;
					else
						st_nxt = seecp_pkg::SEECP_DONE;
				end
			seecp_pkg::SEECP_DAT:
				if (last_dat)
					st_nxt = seecp_pkg::SEECP_DONE;
			seecp_pkg::SEECP_RD:
				st_nxt = seecp_pkg::SEECP_RD;
			seecp_pkg::SEECP_DONE:
				st_nxt = seecp_pkg::SEECP_DONE;
			// Codes six and seven are unused; recover to idle
			default:
				st_nxt = seecp_pkg::SEECP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			st_r <= seecp_pkg::SEECP_IDLE;
		else
			st_r <= st_nxt;
	end

	// Field shift registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 5'h00;
			opc_r <= 2'h0;
			adr_r <= 6'h00;
			dat_r <= 16'h0000;
		end else if (st_r != st_nxt) begin
			cnt_r <= 5'h00;
			if (st_r == seecp_pkg::SEECP_OPC)
				opc_r <= {opc_r[0], di};
			if (st_r == seecp_pkg::SEECP_ADR)
				adr_r <= adr_next;
			if (st_r == seecp_pkg::SEECP_DAT)
				dat_r <= dat_next;
		end else if (sk_rise) begin
			cnt_r <= cnt_inc;
			if (st_r == seecp_pkg::SEECP_OPC)
				opc_r <= {opc_r[0], di};
			if (st_r == seecp_pkg::SEECP_ADR)
				adr_r <= adr_next;
			if (st_r == seecp_pkg::SEECP_DAT)
				dat_r <= dat_next;
		end
	end

	// ------------------------------------------------------------
	// Programming and enable
	// ------------------------------------------------------------
	// Command is complete only in DONE; short cycles do nothing
	wire logic cmd_done = cs_fall && st_r == seecp_pkg::SEECP_DONE;
	wire logic cmd_prog = (opc_r == seecp_pkg::OP_WRITE) ||
		(opc_r == seecp_pkg::OP_ERASE) || cmd_fill ||
		(is_ext && ext == seecp_pkg::EXT_CLEAR);
	wire logic prog_go = cmd_done && cmd_prog && we_r && !prog_r;
	wire logic [15:0] wr_word = (opc_r == seecp_pkg::OP_WRITE || cmd_fill) ?
		dat_r : seecp_pkg::ERASED;
	wire logic wr_all = is_ext;
	wire logic prog_end = prog_r && tmr_r == 32'h0;

	// Only a complete command reaches DONE; a cut cycle changes nothing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			we_r <= 1'b0;
		end else if (cmd_done && is_ext) begin
			if (ext == seecp_pkg::EXT_EN)
				we_r <= 1'b1;
			else if (ext == seecp_pkg::EXT_DIS)
				we_r <= 1'b0;
		end
	end

	// Timer spans the whole self-timed cycle; busy lags it by one edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prog_r <= 1'b0;
			tmr_r <= 32'h0;
		end else if (prog_go) begin
			prog_r <= 1'b1;
			tmr_r <= 32'(PROG_CYCLES - 1);
		end else if (prog_r) begin
			tmr_r <= tmr_r - 32'h1;
			if (prog_end)
				prog_r <= 1'b0;
		end
	end

	// Fields latched at the select fall: a read clocked in while
	// busy shifts adr_r and must not redirect the pending write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prog_adr_r <= 6'h00;
			prog_word_r <= 16'h0000;
			prog_all_r <= 1'b0;
		end else if (prog_go) begin
			prog_adr_r <= adr_r;
			prog_word_r <= wr_word;
			prog_all_r <= wr_all;
		end
	end

	// ------------------------------------------------------------
	// Array
	// ------------------------------------------------------------
	// One select line per word; all of them for fill and clear-all
	logic [seecp_pkg::WORDS-1:0] word_hit;
	for (genvar g = 0; g < seecp_pkg::WORDS; g++) begin : g_hit
		assign word_hit[g] = prog_all_r || prog_adr_r == 6'(g);
	end

	// Array written when the self-timed cycle completes
	always_ff @(posedge clk_sys) begin
		if (prog_end) begin
			for (int i = 0; i < seecp_pkg::WORDS; i++) begin
				if (word_hit[i])
					mem[i] <= prog_word_r;
			end
		end
	end

	// Ready shown after a programming cycle until a start bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ready_show_r <= 1'b0;
		else if (prog_end)
			ready_show_r <= 1'b1;
		else if (start_bit)
			ready_show_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Serial output
	// ------------------------------------------------------------
	// Enable registered beside the data so both move on one edge
	wire logic out_active = cs && (st_r == seecp_pkg::SEECP_RD ||
		prog_r || ready_show_r) && !start_bit;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= 17'h00000;
			do_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= !out_active;
			if (rd_go) begin
				sh_r <= {1'b0, mem[adr_next]};
				do_r <= 1'b0;
			// Read while busy shows busy, never stale shift data
			end else if (st_r == seecp_pkg::SEECP_RD && !prog_r) begin
				if (sk_rise) begin
					do_r <= sh_r[15];
					sh_r <= {sh_r[15:0], 1'b0};
				end
			end else begin
				do_r <= !prog_r;
			end
		end
	end
	assign serial_data_out = do_r;
	assign serial_data_oe_n = oe_n_r;

	// ------------------------------------------------------------
	// Read word stream
	// ------------------------------------------------------------
	// Each read word is also offered to local logic; drops if full
	// Output stage keeps the stream ports on flip-flops; it holds
	// one word beyond the FIFO itself
	logic fifo_valid;
	logic [15:0] fifo_data;
	wire logic fifo_take = !rd_valid || rd_ready;

	seecp_fifo #(
		.WIDTH(seecp_pkg::DATA_W),
		.DEPTH(seecp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.flush(1'b0),
		.in_valid(rd_go),
		.in_ready(),
		.in_data(mem[adr_next]),
		.out_valid(fifo_valid),
		.out_ready(fifo_take),
		.out_data(fifo_data)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
		end else if (fifo_take) begin
			rd_valid <= fifo_valid;
			if (fifo_valid)
				rd_data <= fifo_data;
		end
	end

	// Status ports mirror internal state one edge late
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			write_enabled <= 1'b0;
		end else begin
			busy <= prog_r;
			write_enabled <= we_r;
		end
	end
endmodule : seecp_port

// >>> seecp_port_props.sv
// Checker of the serial EEPROM command port
`timescale 1ns/1ps
module seecp_port_props #(
	parameter int PROG_CYCLES = 50
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic select_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe_n,
	input wire logic busy,
	input wire logic write_enabled,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire logic [15:0] rd_data
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Busy length counted here; a long repetition would crawl
	logic [31:0] busy_cnt_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			busy_cnt_r <= 32'h0;
		else if (busy)
			busy_cnt_r <= busy_cnt_r + 32'h1;
		else
			busy_cnt_r <= 32'h0;
	end
	a_busy_length: assert property ($fell(busy) |->
		busy_cnt_r == 32'(PROG_CYCLES))
		else $error("busy length differs from timer");
	a_idle_hiz: assert property (!select_in [*6] |-> serial_data_oe_n)
		else $error("output driven while deselected");
	a_prog_cause: assert property ($rose(busy) |-> write_enabled && !select_in)
		else $error("programming without enable or select fall");
	a_prog_hold: assert property ($rose(busy) |=> busy [*8])
		else $error("busy too short");
	a_enable_fall: assert property ($changed(write_enabled) |-> !select_in)
		else $error("enable changed while selected");
	a_busy_low: assert property ((busy && select_in) [*5] |->
		!serial_data_oe_n && !serial_data_out)
		else $error("busy not shown low");
	a_enable_steady: assert property (select_in [*8] |-> $stable(write_enabled))
		else $error("enable moved mid cycle");
	a_out_steady: assert property ((select_in && !serial_clock_in && !busy) [*6]
		|-> $stable(serial_data_out))
		else $error("output moved without clock rise");
	a_word_hold: assert property (rd_valid && !rd_ready |=>
		rd_valid && $stable(rd_data))
		else $error("read word dropped while stalled");
endmodule : seecp_port_props
bind seecp_port seecp_port_props #(.PROG_CYCLES(PROG_CYCLES))
	seecp_port_props_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .select_in(select_in),
	.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
	.busy(busy), .write_enabled(write_enabled), .rd_valid(rd_valid),
	.rd_ready(rd_ready), .rd_data(rd_data));

// >>> seecp_port_tb_top.sv
// Testbench of the serial EEPROM command port
`timescale 1ns/1ps
module seecp_port_tb_top;
	// -----
	// Bench
	// -----
	logic clk_sys = 0;
	logic rst_n = 0;
	logic rd_ready = 0;
	wire select_in, serial_clock_in, serial_data_in, serial_data_out;
	wire serial_data_oe_n, busy, write_enabled, rd_valid;
	wire [15:0] rd_data;
	int error_cnt = 0;
	int checked = 0;
	seecp_port #(.PROG_CYCLES(300)) seecp_port_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .select_in(select_in),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
		.busy(busy), .write_enabled(write_enabled), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data));
	seecp_master seecp_master_inst (.select_in(select_in),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk
	task automatic cmd(input logic [7:0] oa, input logic [15:0] d, input bit pr);
		logic r;
		if (oa[7:6] == 2'h1 || oa[7:4] == 4'h1)
			seecp_master_inst.cycle(27'({1'b1, oa, d}), 25, 0);
		else
			seecp_master_inst.cycle(27'({1'b1, oa}), 9, 0);
		if (pr) begin
			chk(busy, 1);
			seecp_master_inst.poll(r);
			chk(r, 0);
			for (int i = 0; i < 20 && r !== 1'b1; i++) seecp_master_inst.poll(r);
			chk(r, 1);
		end
	endtask : cmd
	// Two leading zeros on every read
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		seecp_master_inst.cycle(27'({2'h0, 1'b1, seecp_pkg::OP_READ, a}),
			11, 1);
		chk(seecp_master_inst.q, {1'b0, exp});
	endtask : rd
	task automatic drain(input bit full);
		int n;
		n = 0;
		while (rd_valid === 1'b1 && n < 40) begin
			if (full) chk({1'b0, rd_data}, 17'h01234);
			@(negedge clk_sys) rd_ready = 1;
			@(negedge clk_sys) rd_ready = 0;
			n++;
		end
		if (full) chk(17'(n), 17'(seecp_pkg::FIFO_DEPTH + 1));
	endtask : drain
	task automatic tally_and_finish;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(negedge clk_sys);
		rst_n = 1;
		#100;
		chk(write_enabled, 0);
		cmd(8'h3A, 16'h0000, 0);
		chk(write_enabled, 1);
		cmd(8'h25, 16'h0000, 1);
		rd(6'h00, 16'hFFFF);
		rd(6'h3F, 16'hFFFF);
		cmd(8'h45, 16'hA5C3, 1);
		rd(6'h05, 16'hA5C3);
		rd(6'h06, 16'hFFFF);
		cmd(8'h10, 16'h1234, 1);
		cmd(8'hC7, 16'h0000, 1);
		rd(6'h07, 16'hFFFF);
		rd(6'h08, 16'h1234);
		cmd(8'h03, 16'h0000, 0);
		chk(write_enabled, 0);
		cmd(8'h48, 16'h0000, 0);
		chk(busy, 0);
		cmd(8'h22, 16'h0000, 0);
		chk(busy, 0);
		drain(0);
		repeat (seecp_pkg::FIFO_DEPTH + 2) rd(6'h08, 16'h1234);
		drain(1);
		tally_and_finish();
	end
	initial begin
		#900000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : seecp_port_tb_top
